// file: src/wdfi_top.sv
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module wdfi_top
  import wdfi_pkg::*;
#(
  parameter int TXD_DOM_CYCLES = wdfi_pkg::TXD_DOM_CYC,
  parameter int BUS_DOM_CYCLES = wdfi_pkg::BUS_DOM_CYC,
  parameter int INT_HIGH_CYCLES = wdfi_pkg::INT_MIN_HIGH_CYC,
  parameter int STARTUP_CYCLES = wdfi_pkg::STARTUP_WD_CYC,
  parameter int WD_BASE_CYCLES = wdfi_pkg::WD_BASE_CYC,
  parameter int RST_CYCLES = wdfi_pkg::RST_PULSE_CYC,
  parameter int SUP_FLAGS = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Transceiver side pins
  input wire logic txd_in,
  input wire logic rxd_in,
  output logic tx_enable,
  // Flag sources; supply bit 0 is first_regulator_output undervoltage
  input wire logic [1:0] temp_flag_in,
  input wire logic [SUP_FLAGS-1:0] supply_uv_in,
  // System outputs
  output logic reset_out_n,
  output logic interrupt_out_n,
  output logic [1:0] op_mode
);
  initial begin
    if (SUP_FLAGS < 1 || SUP_FLAGS > 8) $error("wdfi_top: SUP_FLAGS out of 1..8");
    if (WD_BASE_CYCLES < 2 || WD_BASE_CYCLES > 16000000) $error("wdfi_top: bad WD_BASE_CYCLES");
    if (STARTUP_CYCLES < 1 || RST_CYCLES < 1 || INT_HIGH_CYCLES < 1) $error("wdfi_top: bad count");
    if (INT_HIGH_CYCLES > 65535) $error("wdfi_top: INT_HIGH_CYCLES exceeds the hold timer");
  end

  // Synchronised inputs
  logic txd_s;
  logic rxd_s;
  logic [1:0] temp_s;
  logic [SUP_FLAGS-1:0] sup_s;
  logic txd_held;
  logic bus_held;

  wdfi_sync #(.WIDTH(2)) u_sync_link (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({txd_in, rxd_in}),
    .sync_out({txd_s, rxd_s})
  );

  wdfi_sync #(.WIDTH(2 + SUP_FLAGS)) u_sync_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({temp_flag_in, supply_uv_in}),
    .sync_out({temp_s, sup_s})
  );

  wdfi_low_timer #(.LIMIT(TXD_DOM_CYCLES)) u_txd_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .level_in(txd_s),
    .held(txd_held)
  );

  wdfi_low_timer #(.LIMIT(BUS_DOM_CYCLES)) u_bus_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .level_in(rxd_s),
    .held(bus_held)
  );

  // Bus handshakes: write address and data are taken together
  logic wr_go;
  logic rd_go;
  logic [31:0] wmask;
  logic [31:0] wval;
  assign wr_go = awvalid & wvalid & ~bvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign rd_go = arvalid & ~rvalid;
  assign arready = rd_go;
  assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  assign wval = wdata & wmask;

  // Write and read decode
  logic wr_ctrl;
  logic wr_trig;
  logic wr_ibus;
  logic wr_itemp;
  logic wr_isup;
  logic wr_hit;
  logic rd_fault;
  logic rd_reason;
  assign wr_ctrl = wr_go && awaddr == OFS_CTRL;
  assign wr_trig = wr_go && awaddr == OFS_WD_TRIG;
  assign wr_ibus = wr_go && awaddr == OFS_INT_BUS;
  assign wr_itemp = wr_go && awaddr == OFS_INT_TEMP;
  assign wr_isup = wr_go && awaddr == OFS_INT_SUP;
  assign wr_hit = wr_ctrl | wr_trig | wr_ibus | wr_itemp | wr_isup;
  assign rd_fault = rd_go && araddr == OFS_FAULT;
  assign rd_reason = rd_go && araddr == OFS_RST_REASON;

  // Local failure state
  logic tx_block;
  logic short_flag;
  logic dclamp_flag;
  logic bclamp_flag;
  logic txd_held_d;
  logic bus_held_d;
  logic txd_trip;
  logic bus_trip;
  logic short_trip;
  assign txd_trip = txd_held & ~txd_held_d;
  assign bus_trip = bus_held & ~bus_held_d;
  // A trip with receive also dominant is told apart as a short
  assign short_trip = txd_trip & ~rxd_s;
  assign tx_enable = ~tx_block;

  // Transmitter lock and short tracking; op_mode is not touched here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_held_d <= 1'b0;
      bus_held_d <= 1'b0;
      tx_block <= 1'b0;
      short_flag <= 1'b0;
    end else begin
      txd_held_d <= txd_held;
      bus_held_d <= bus_held;
      if (txd_trip) begin
        tx_block <= 1'b1;
        short_flag <= short_trip;
      end else if (short_flag && !txd_s) begin
        short_flag <= ~rxd_s;
      end else if (!short_flag && txd_s) begin
        tx_block <= 1'b0;
      end
    end
  end

  // Clear-on-read clamp flags; a trip in the read cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dclamp_flag <= 1'b0;
      bclamp_flag <= 1'b0;
    end else begin
      dclamp_flag <= (dclamp_flag & ~rd_fault) | (txd_trip & ~short_trip);
      bclamp_flag <= (bclamp_flag & ~rd_fault) | bus_trip;
    end
  end

  // Control register
  logic [1:0] mode;
  logic [2:0] win_sel;
  logic [2:0] tout_sel;
  logic go_sleep;
  logic win_open;
  logic [1:0] next_mode;
  assign next_mode = go_sleep ? MODE_SLEEP :
    wr_ctrl && wstrb[0] ? wdata[CTRL_MODE_LSB +: 2] : mode;
  assign op_mode = mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_NORMAL;
      win_sel <= WIN_SEL_RST;
      tout_sel <= TOUT_SEL_RST;
    end else begin
      mode <= next_mode;
      if (wr_ctrl && wstrb[0] && win_open) begin
        win_sel <= wdata[CTRL_WIN_LSB +: 3];
      end
      if (wr_ctrl && wstrb[1]) begin
        tout_sel <= wdata[CTRL_TOUT_LSB +: 3];
      end
    end
  end

  // Watchdog timing
  wdfi_wd_state_t wd_state;
  wdfi_wd_state_t next_wd_state;
  logic [31:0] wd_cnt;
  logic [31:0] next_wd_cnt;
  logic [1:0] fails;
  logic [1:0] next_fails;
  logic [3:0] fire_cause;
  logic [31:0] win_period;
  logic [31:0] tout_period;
  logic uv_first;
  assign win_period = 32'(WD_BASE_CYCLES) << win_sel;
  assign tout_period = 32'(WD_BASE_CYCLES) << tout_sel;
  assign uv_first = sup_s[0];
  // Outside window mode the period may be changed freely
  assign win_open = wd_state != WD_WINDOW || wd_cnt >= (win_period >> 1);

  always_comb begin
    next_wd_state = wd_state;
    next_wd_cnt = uv_first ? wd_cnt : wd_cnt + 32'h1;
    next_fails = fails;
    fire_cause = 4'h0;
    go_sleep = 1'b0;
    unique case (wd_state)
      WD_STARTUP: begin
        if (wr_trig) begin
          next_fails = 2'h0;
          next_wd_cnt = 32'h0;
          if (mode == MODE_NORMAL) begin
            next_wd_state = WD_WINDOW;
          end else if (mode == MODE_STANDBY) begin
            next_wd_state = WD_TIMEOUT;
          end
        end else if (!uv_first && wd_cnt >= 32'(STARTUP_CYCLES - 1)) begin
          next_wd_cnt = 32'h0;
          if (fails == 2'(STARTUP_TRIES - 1)) begin
            next_fails = 2'h0;
            go_sleep = 1'b1;
            next_wd_state = WD_OFF;
          end else begin
            next_fails = fails + 2'h1;
            fire_cause[RR_STARTUP] = 1'b1;
            next_wd_state = WD_RESET;
          end
        end
      end
      WD_WINDOW: begin
        if (mode == MODE_STANDBY) begin
          next_wd_state = WD_TIMEOUT;
          next_wd_cnt = 32'h0;
        end else if (wr_trig && !win_open) begin
          fire_cause[RR_EARLY] = 1'b1;
          next_wd_state = WD_RESET;
          next_wd_cnt = 32'h0;
        end else if (wr_trig) begin
          next_wd_cnt = 32'h0;
        end else if (!uv_first && wd_cnt >= win_period - 32'h1) begin
          fire_cause[RR_LATE] = 1'b1;
          next_wd_state = WD_RESET;
          next_wd_cnt = 32'h0;
        end
      end
      WD_TIMEOUT: begin
        if (mode == MODE_NORMAL) begin
          next_wd_state = WD_WINDOW;
          next_wd_cnt = 32'h0;
        end else if (wr_trig) begin
          next_wd_cnt = 32'h0;
        end else if (!uv_first && wd_cnt >= tout_period - 32'h1) begin
          fire_cause[RR_TIMEOUT] = 1'b1;
          next_wd_state = WD_RESET;
          next_wd_cnt = 32'h0;
        end
      end
      WD_RESET: begin
        next_wd_cnt = wd_cnt + 32'h1;
        if (wd_cnt >= 32'(RST_CYCLES - 1)) begin
          next_wd_state = WD_STARTUP;
          next_wd_cnt = 32'h0;
        end
      end
      WD_OFF: begin
        next_wd_cnt = 32'h0;
        if (mode != MODE_SLEEP) begin
          next_wd_state = WD_STARTUP;
        end
      end
      default: begin
        next_wd_state = WD_STARTUP;
        next_wd_cnt = 32'h0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_state <= WD_STARTUP;
      wd_cnt <= 32'h0;
      fails <= 2'h0;
      reset_out_n <= 1'b1;
    end else begin
      wd_state <= next_wd_state;
      wd_cnt <= next_wd_cnt;
      fails <= next_fails;
      reset_out_n <= next_wd_state != WD_RESET;
    end
  end

  // Reset reason: cause latched as reset falls, read clears, new cause wins
  logic [4:0] reason;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reason <= RR_RST;
    end else if (|fire_cause) begin
      reason <= {1'b0, fire_cause};
    end else if (rd_reason) begin
      reason <= 5'h00;
    end
  end

  // Interrupt sources: edges of flags, write-one-to-clear
  logic [2:0] src_bus;
  logic [1:0] src_temp;
  logic [SUP_FLAGS-1:0] src_sup;
  logic [1:0] temp_d;
  logic [SUP_FLAGS-1:0] sup_d;
  logic [2:0] ev_bus;
  logic [1:0] ev_temp;
  logic [SUP_FLAGS-1:0] ev_sup;
  logic [2:0] top;
  logic src_cleared;
  logic [15:0] hold_cnt;
  assign ev_bus = {bus_trip, short_trip, txd_trip & ~short_trip};
  assign ev_temp = temp_s & ~temp_d;
  assign ev_sup = sup_s & ~sup_d;
  assign top = {|src_sup, |src_temp, |src_bus};
  assign src_cleared = (wr_ibus && |(wval[2:0] & src_bus)) ||
    (wr_itemp && |(wval[1:0] & src_temp)) ||
    (wr_isup && |(wval[SUP_FLAGS-1:0] & src_sup));
  // High for the minimum time after a clear, then low if anything pends
  assign interrupt_out_n = ~(|top) || hold_cnt != 16'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn || !reset_out_n) begin
      src_bus <= 3'h0;
      src_temp <= 2'h0;
      src_sup <= '0;
    end else begin
      src_bus <= (src_bus & ~(wr_ibus ? wval[2:0] : 3'h0)) | ev_bus;
      src_temp <= (src_temp & ~(wr_itemp ? wval[1:0] : 2'h0)) | ev_temp;
      src_sup <= (src_sup & ~(wr_isup ? wval[SUP_FLAGS-1:0] : '0)) | ev_sup;
    end
  end

  // Edge history and minimum high timer; 16 bits hold the longest figure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_d <= 2'h3; // Matches the synchroniser's reset level, so release shows no false edge
      sup_d <= '1;
      hold_cnt <= 16'h0;
    end else begin
      temp_d <= temp_s;
      sup_d <= sup_s;
      if (src_cleared) begin
        hold_cnt <= 16'(INT_HIGH_CYCLES);
      end else if (hold_cnt != 16'h0) begin
        hold_cnt <= hold_cnt - 16'h1;
      end
    end
  end

  // Read mux; only reads of the fault and reset reason registers carry side effects (clear on read)
  logic [31:0] rd_val;
  logic rd_hit;
  assign rd_hit = araddr <= OFS_WD_STAT && araddr[1:0] == 2'h0;
  always_comb begin
    rd_val = 32'h0;
    unique case (araddr)
      OFS_CTRL: rd_val = {21'h0, tout_sel, 1'b0, win_sel, 2'h0, mode};
      OFS_INT_TOP: rd_val = {29'h0, top};
      OFS_INT_BUS: rd_val = {29'h0, src_bus};
      OFS_INT_TEMP: rd_val = {30'h0, src_temp};
      OFS_INT_SUP: rd_val = 32'(src_sup);
      OFS_BUS_STAT: rd_val = {28'h0, tx_block, ~bus_held, ~txd_held, rxd_s};
      OFS_FAULT: rd_val = {29'h0, short_flag, bclamp_flag, dclamp_flag};
      OFS_TEMP_STAT: rd_val = {30'h0, temp_s};
      OFS_SUP_STAT: rd_val = 32'(sup_s);
      OFS_RST_REASON: rd_val = {27'h0, reason};
      OFS_WD_STAT: rd_val = {26'h0, fails, 1'b0, wd_state};
      default: rd_val = 32'h0;
    endcase
  end

  // Bus response registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0;
    end else begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (rd_go) begin
        rvalid <= 1'b1;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata <= rd_val;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/wdfi_pkg.sv
package wdfi_pkg;
  // Clock and timing figures
  localparam int CLK_NS = 8;
  localparam int TXD_DOM_TIMEOUT_NS = 1000000;
  localparam int BUS_DOM_TIMEOUT_NS = 1000000;
  localparam int INT_MIN_HIGH_NS = 100000;
  localparam int STARTUP_WD_PERIOD_NS = 256000000;
  localparam int WD_BASE_PERIOD_NS = 4000000;
  localparam int RST_PULSE_NS = 2000000;
  // Least times round up to whole cycles
  localparam int TXD_DOM_CYC = (TXD_DOM_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUS_DOM_CYC = (BUS_DOM_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int INT_MIN_HIGH_CYC = (INT_MIN_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int STARTUP_WD_CYC = STARTUP_WD_PERIOD_NS / CLK_NS;
  localparam int WD_BASE_CYC = WD_BASE_PERIOD_NS / CLK_NS;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STARTUP_TRIES = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WD_TRIG = 8'h04;
  localparam logic [7:0] OFS_INT_TOP = 8'h08;
  localparam logic [7:0] OFS_INT_BUS = 8'h0C;
  localparam logic [7:0] OFS_INT_TEMP = 8'h10;
  localparam logic [7:0] OFS_INT_SUP = 8'h14;
  localparam logic [7:0] OFS_BUS_STAT = 8'h18;
  localparam logic [7:0] OFS_FAULT = 8'h1C;
  localparam logic [7:0] OFS_TEMP_STAT = 8'h20;
  localparam logic [7:0] OFS_SUP_STAT = 8'h24;
  localparam logic [7:0] OFS_RST_REASON = 8'h28;
  localparam logic [7:0] OFS_WD_STAT = 8'h2C;

  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WIN_LSB = 4;
  localparam int CTRL_TOUT_LSB = 8;
  localparam logic [2:0] WIN_SEL_RST = 3'h0;
  localparam logic [2:0] TOUT_SEL_RST = 3'h0;

  // Reset reason bits
  localparam int RR_STARTUP = 0;
  localparam int RR_EARLY = 1;
  localparam int RR_LATE = 2;
  localparam int RR_TIMEOUT = 3;
  localparam int RR_EXT = 4;
  localparam logic [4:0] RR_RST = 5'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_SLEEP = 2'b10,
    MODE_RX_ONLY = 2'b11
  } wdfi_mode_t;

  typedef enum logic [2:0] {
    WD_STARTUP = 3'b000,
    WD_WINDOW = 3'b001,
    WD_TIMEOUT = 3'b010,
    WD_RESET = 3'b011,
    WD_OFF = 3'b100
  } wdfi_wd_state_t;
endpackage

// file: src/wdfi_sync.sv
`timescale 1ns/1ns
`default_nettype none
module wdfi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Async in, filtered out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] agree;

  // A change counts only once stages two and three agree
  assign agree = ~(s2 ^ s3);

  // Three-flop chain; s1 feeds s2 and nothing else
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      sync_out <= '1;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= (s2 & agree) | (sync_out & ~agree);
    end
  end
endmodule
`default_nettype wire

// file: src/wdfi_low_timer.sv
`timescale 1ns/1ns
`default_nettype none
module wdfi_low_timer #(
  parameter int LIMIT = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched level, dominant when low
  input wire logic level_in,
  output logic held
);
  logic [31:0] cnt;

  initial begin
    if (LIMIT < 1) $error("wdfi_low_timer: LIMIT must be at least 1");
  end

  // Counts low cycles; held stays up until the level returns high
  always_ff @(posedge aclk) begin
    if (!aresetn || level_in) begin
      cnt <= 32'h0;
      held <= 1'b0;
    end else if (!held) begin
      cnt <= cnt + 32'h1;
      held <= (cnt >= 32'(LIMIT - 1));
    end
  end
endmodule
`default_nettype wire

// file: sim/wdfi_chk.sv
`timescale 1ns/1ns
`default_nettype none
module wdfi_chk #(
  parameter int TXD_DOM_CYCLES = 100
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Pins
  input wire logic txd_in,
  input wire logic tx_enable,
  input wire logic reset_out_n,
  input wire logic interrupt_out_n
);
  logic [7:0] low_cnt;
  // Dominant run length, restarted by any system reset
  always_ff @(posedge aclk) begin
    if (!aresetn || !reset_out_n || txd_in) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take; awvalid && wvalid && !bvalid; endsequence
  sequence s_rd_take; arvalid && !rvalid; endsequence
  // Pulse length assumes the bench sets the reset pulse to 5 cycles
  sequence s_rst_pulse; !reset_out_n [*5] ##1 reset_out_n; endsequence
  a_write_answer: assert property (s_wr_take |=> bvalid)
    else $error("write taken without answer");
  a_answer_single: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  a_read_answer: assert property (s_rd_take |=> rvalid)
    else $error("read taken without answer");
  a_unmapped_read: assert property (s_rd_take and araddr > 8'h2C |=>
    rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read not refused");
  a_txd_clamp: assert property (low_cnt == TXD_DOM_CYCLES + 8 |-> !tx_enable)
    else $error("transmitter left on under clamp");
  a_reset_pulse: assert property ($fell(reset_out_n) |-> s_rst_pulse)
    else $error("reset pulse length wrong");
  a_irq_in_reset: assert property (!reset_out_n && $past(!reset_out_n) |->
    interrupt_out_n) else $error("interrupt kept through reset");
  a_irq_hold: assert property ($rose(interrupt_out_n) && reset_out_n &&
    $past(reset_out_n) && $past(aresetn) |-> interrupt_out_n [*8])
    else $error("interrupt high time too short");
endmodule
bind wdfi_top wdfi_chk #(.TXD_DOM_CYCLES(TXD_DOM_CYCLES)) u_chk (.aclk(aclk),
  .aresetn(aresetn), .awvalid(awvalid), .wvalid(wvalid), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .rvalid(rvalid),
  .rdata(rdata), .rresp(rresp), .txd_in(txd_in), .tx_enable(tx_enable),
  .reset_out_n(reset_out_n), .interrupt_out_n(interrupt_out_n));
`default_nettype wire

// file: sim/wdfi_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
module wdfi_pins_model (
  // Clock
  input wire logic aclk,
  // Pins towards the block, low is dominant
  output logic txd_in,
  output logic rxd_in
);
  logic txd_drv = 1'b1;
  logic bus_drv = 1'b1;
  logic short_on = 1'b0;
  // A shorted pair pulls both pins dominant together
  assign txd_in = short_on ? (txd_drv & bus_drv) : txd_drv;
  assign rxd_in = short_on ? (txd_drv & bus_drv) : bus_drv;
  // Levels change just after an edge
  task automatic drive(input logic t, input logic b, input logic s);
    @(posedge aclk);
    txd_drv <= t;
    bus_drv <= b;
    short_on <= s;
  endtask
  // Recovery probe, off the clock grid like a real host
  task automatic probe();
    @(posedge aclk);
    #1;
    txd_drv = 1'b0;
    #500;
    txd_drv = 1'b1;
    #500;
    txd_drv = 1'b0;
    #500;
    txd_drv = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: sim/wdfi_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module wdfi_top_tb_top;
  import wdfi_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, seen_rst;
  logic awready, wready, bvalid, arready, rvalid, txd_in, rxd_in, tx_enable;
  logic reset_out_n, interrupt_out_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [1:0] bresp, rresp, wr_r, op_mode, temp_flag_in;
  logic [3:0] supply_uv_in, wstrb;
  logic [2:0] awprot, arprot;
  int err_total = 0;
  int total_checks = 0;
  // Short counts keep the run brief; the interrupt high time keeps its full figure
  wdfi_top #(.TXD_DOM_CYCLES(100), .BUS_DOM_CYCLES(20),
    .STARTUP_CYCLES(200), .WD_BASE_CYCLES(40), .RST_CYCLES(5)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .txd_in(txd_in), .rxd_in(rxd_in), .tx_enable(tx_enable),
    .temp_flag_in(temp_flag_in), .supply_uv_in(supply_uv_in),
    .reset_out_n(reset_out_n), .interrupt_out_n(interrupt_out_n), .op_mode(op_mode));
  wdfi_pins_model u_pins (.aclk(aclk), .txd_in(txd_in), .rxd_in(rxd_in));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watched signal by code; values seen at the falling edge are settled
  function automatic logic [1:0] sel(input int w);
    case (w)
      0: return {1'b0, reset_out_n};
      1: return op_mode;
      2: return {1'b0, awready};
      3: return {1'b0, bvalid};
      4: return {1'b0, arready};
      default: return {1'b0, rvalid};
    endcase
  endfunction
  // Bounded wait; a hang counts as a mismatch
  task automatic wait_until(input int w, input logic [1:0] v);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      if (n > 1000) begin
        err_total++;
        end_sim();
      end
    end while (sel(w) !== v);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wait_until(2, 2'h1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_until(3, 2'h1);
    wr_r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_until(4, 2'h1);
    @(posedge aclk);
    arvalid <= 1'b0;
    wait_until(5, 2'h1);
    rd_d = rdata;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_d, e)
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, temp_flag_in, supply_uv_in} = '0;
    {awprot, arprot, wstrb} = 10'h00F;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFS_RST_REASON, 32'h10);
    rdc(OFS_RST_REASON, 32'h0);
    rd(8'h30);
    `CHK(rd_d, 32'h0)
    wr(8'h30, 32'h1);
    `CHK(wr_r, RESP_SLVERR)
    wr(OFS_CTRL, 32'h70);
    rdc(OFS_CTRL, 32'h70);
    wr(OFS_WD_TRIG, 32'h1);
    rdc(OFS_WD_STAT, 32'h1);
    // Transmit clamp, then a bus clamp while the transmit side is free
    u_pins.drive(1'b0, 1'b1, 1'b0);
    cyc(120);
    `CHK({tx_enable, op_mode, interrupt_out_n}, 4'h0)
    u_pins.drive(1'b1, 1'b0, 1'b0);
    cyc(40);
    u_pins.drive(1'b1, 1'b1, 1'b0);
    cyc(8);
    `CHK(tx_enable, 1'b1)
    rdc(OFS_FAULT, 32'h3);
    rdc(OFS_FAULT, 32'h0);
    rdc(OFS_BUS_STAT, 32'h7);
    rdc(OFS_BUS_STAT, 32'h7);
    rdc(OFS_INT_TOP, 32'h1);
    wr(OFS_INT_BUS, 32'h0);
    rdc(OFS_INT_BUS, 32'h5);
    wr(OFS_INT_BUS, 32'h1);
    `CHK(interrupt_out_n, 1'b1)
    // Serve the window every 3000 cycles while the full high time runs
    repeat (4) begin
      cyc(3000);
      wr(OFS_WD_TRIG, 32'h1);
      `CHK(interrupt_out_n, 1'b1)
    end
    cyc(INT_MIN_HIGH_CYC - 11900);
    `CHK(interrupt_out_n, 1'b0)
    wr(OFS_INT_BUS, 32'h4);
    rdc(OFS_INT_TOP, 32'h0);
    // Shorted pair, then recovery by the host probe
    u_pins.drive(1'b0, 1'b1, 1'b1);
    cyc(120);
    `CHK(tx_enable, 1'b0)
    u_pins.drive(1'b1, 1'b1, 1'b0);
    cyc(8);
    // The shorted pair holds the bus dominant too, so the bus clamp trips first
    rdc(OFS_FAULT, 32'h6);
    u_pins.probe();
    cyc(8);
    rdc(OFS_FAULT, 32'h0);
    `CHK(tx_enable, 1'b1)
    rdc(OFS_INT_BUS, 32'h6);
    wr(OFS_INT_BUS, 32'h6);
    // Period is 5120 cycles: this lands in the open half
    cyc(2600);
    wr(OFS_WD_TRIG, 32'h1);
    rdc(OFS_WD_STAT, 32'h1);
    temp_flag_in <= 2'h1;
    supply_uv_in <= 4'h1;
    seen_rst = 1'b0;
    repeat (6000) begin
      @(negedge aclk);
      if (reset_out_n !== 1'b1) seen_rst = 1'b1;
    end
    `CHK(seen_rst, 1'b0)
    rdc(OFS_INT_TOP, 32'h6);
    rdc(OFS_TEMP_STAT, 32'h1);
    rdc(OFS_SUP_STAT, 32'h1);
    temp_flag_in <= 2'h0;
    supply_uv_in <= 4'h0;
    wr(OFS_INT_TEMP, 32'h1);
    wr(OFS_INT_SUP, 32'h1);
    rdc(OFS_INT_TOP, 32'h0);
    // Early trigger, then three unserved start-up periods
    wr(OFS_WD_TRIG, 32'h1);
    wait_until(0, 2'h0);
    wait_until(0, 2'h1);
    rdc(OFS_RST_REASON, 32'h2);
    rdc(OFS_WD_STAT, 32'h0);
    wait_until(0, 2'h0);
    wait_until(0, 2'h1);
    rdc(OFS_RST_REASON, 32'h1);
    wait_until(0, 2'h0);
    wait_until(0, 2'h1);
    wait_until(1, MODE_SLEEP);
    `CHK(reset_out_n, 1'b1)
    // Standby timeout watchdog, served once, then left to expire
    wr(OFS_CTRL, 32'h1);
    // Lane one alone picks the second timeout period; the mode lane is masked
    wstrb <= 4'h2;
    wr(OFS_CTRL, 32'h102);
    wstrb <= 4'hF;
    rdc(OFS_CTRL, 32'h101);
    wr(OFS_WD_TRIG, 32'h1);
    rdc(OFS_WD_STAT, 32'h2);
    cyc(20);
    wr(OFS_WD_TRIG, 32'h1);
    cyc(20);
    `CHK(reset_out_n, 1'b1)
    wait_until(0, 2'h0);
    wait_until(0, 2'h1);
    rdc(OFS_RST_REASON, 32'h8);
    end_sim();
  end
endmodule
`default_nettype wire
